//--- msx_pkg.sv
// Constants and types for the store and multiply execution unit.
// Assumes a core that supplies one 16-bit instruction word per four-phase cycle.
// Contract
// RL1: Store copies accumulator into addressed file register.
// RL2: Access bit zero access bank, one bank select.
// RL3: Extended set, address up to 95: indexed.
// RL4: Multiply literal: accumulator times literal, unsigned.
// RL5: Literal product high and low bytes stored.
// RL6: Multiply literal leaves accumulator unchanged.
// RL7: Multiply register: accumulator times file register.
// RL8: Register product stored; accumulator, source unchanged.
// RL9: Multiplies touch no status flag at all.
// RL10: One word, one cycle, four phases.
package msx_pkg;
    localparam logic [6:0] MSX_OP_STORE = 7'h37;
    localparam logic [6:0] MSX_OP_MULREG = 7'h01;
    localparam logic [7:0] MSX_OP_MULLIT = 8'h0d;
    localparam logic [7:0] MSX_ILO_MAX = 8'h5f;
    localparam logic [7:0] MSX_ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] MSX_ACCESS_HI_BANK = 4'hf;
    localparam logic [1:0] MSX_Q_LAST = 2'h3;
    localparam int MSX_INSTR_MSB = 15;
    localparam int MSX_OP7_LSB = 9;
    localparam int MSX_OP8_LSB = 8;
    localparam int MSX_ACCESS_BIT = 8;
    localparam int MSX_FILE_MSB = 7;
    localparam int MSX_FILE_LSB = 0;
    localparam logic [3:0] MSX_BANK_ZERO = 4'h0;
    typedef enum logic [1:0] {MSX_Q1, MSX_Q2, MSX_Q3, MSX_Q4} msx_phase_t;
    typedef enum logic [1:0] {MSX_NONE, MSX_STORE, MSX_MULLIT, MSX_MULREG} msx_kind_t;
    typedef struct packed {
        msx_phase_t phase;
        msx_kind_t kind;
        logic [11:0] addr;
        logic [7:0] operand;
        logic [15:0] product;
        logic [7:0] prod_hi;
        logic [7:0] prod_lo;
        logic wr_en;
        logic [11:0] wr_addr;
        logic [7:0] wr_data;
    } msx_state_t;
endpackage : msx_pkg

//--- msx_exec.sv
// Execution unit for store-accumulator and the two unsigned multiplies.
// Assumes file reads answer combinationally within the read phase.
module msx_exec (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] instr,
    input wire logic [7:0] accum,
    input wire logic [3:0] bank_select_reg,
    input wire logic ext_set_en,
    input wire logic [7:0] fsr2_base,
    output logic [11:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic [11:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [7:0] product_high_byte,
    output logic [7:0] product_low_byte,
    output logic [1:0] phase,
    output logic status_we
);
    import msx_pkg::*;
    msx_state_t s_r, s_nxt;
    logic [6:0] op_seven;
    logic [7:0] op_eight;
    logic access_sel;
    logic [7:0] file_field;
    msx_kind_t decoded_kind;

    // Fields are sliced once so that the decode and the checks read the same bits.
    assign op_seven = instr[MSX_INSTR_MSB:MSX_OP7_LSB];
    assign op_eight = instr[MSX_INSTR_MSB:MSX_OP8_LSB];
    assign access_sel = instr[MSX_ACCESS_BIT];
    assign file_field = instr[MSX_FILE_MSB:MSX_FILE_LSB];

    // RL1 RL4 RL7 opcode decode
    // Unknown opcodes decode to no operation, so the unit idles for that cycle.
    function automatic msx_kind_t decode_kind(input logic [6:0] op7, input logic [7:0] op8);
        if (op7 == MSX_OP_STORE) begin
            return MSX_STORE;
        end
        if (op8 == MSX_OP_MULLIT) begin
            return MSX_MULLIT;
        end
        if (op7 == MSX_OP_MULREG) begin
            return MSX_MULREG;
        end
        return MSX_NONE;
    endfunction : decode_kind

    assign decoded_kind = decode_kind(op_seven, op_eight);

    function automatic logic [11:0] resolve(input logic a, input logic [7:0] f,
                                            input logic [3:0] bank_sel, input logic ext,
                                            input logic [7:0] base);
        // RL3 indexed literal offset
        // The offset wraps inside bank zero; only the low byte of base plus offset is kept.
        if (!a && ext && f <= MSX_ILO_MAX) begin
            return {MSX_BANK_ZERO, 8'(base + f)};
        end
        // RL2 access bank split
        if (!a) begin
            return (f < MSX_ACCESS_SPLIT) ? {MSX_BANK_ZERO, f} : {MSX_ACCESS_HI_BANK, f};
        end
        // RL2 bank select register
        return {bank_sel, f};
    endfunction : resolve

    always_comb begin
        s_nxt = s_r;
        s_nxt.wr_en = 1'b0;
        // RL10 four phase sequence
        unique case (s_r.phase)
            MSX_Q1: begin
                s_nxt.phase = MSX_Q2;
                s_nxt.addr = resolve(access_sel, file_field, bank_select_reg, ext_set_en,
                                     fsr2_base);
                s_nxt.kind = decoded_kind;
            end
            MSX_Q2: begin
                s_nxt.phase = MSX_Q3;
                // RL7 RL4 operand read
                // The file answers combinationally, so read data must settle within Q2.
                s_nxt.operand = (s_r.kind == MSX_MULLIT) ? file_field : rd_data;
            end
            MSX_Q3: begin
                s_nxt.phase = MSX_Q4;
                // RL4 unsigned eight by eight
                // Both factors are widened first so the upper byte is never lost.
                s_nxt.product = 16'(accum) * 16'(s_r.operand);
            end
            MSX_Q4: begin
                s_nxt.phase = MSX_Q1;
                // RL5 RL8 product pair written
                if (s_r.kind == MSX_MULLIT || s_r.kind == MSX_MULREG) begin
                    s_nxt.prod_hi = s_r.product[15:8];
                    s_nxt.prod_lo = s_r.product[7:0];
                end
                // RL1 accumulator to file
                // The strobe is registered, so the file sees it one clock after Q4.
                if (s_r.kind == MSX_STORE) begin
                    s_nxt.wr_en = 1'b1;
                    s_nxt.wr_addr = s_r.addr;
                    s_nxt.wr_data = accum;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) s_r <= '0;
        else s_r <= s_nxt;
    end

    // Every output but the constant status_we comes straight from the state register, so none of them glitch.
    assign rd_addr = s_r.addr;
    assign wr_en = s_r.wr_en;
    assign wr_addr = s_r.wr_addr;
    assign wr_data = s_r.wr_data;
    assign product_high_byte = s_r.prod_hi;
    assign product_low_byte = s_r.prod_lo;
    assign phase = s_r.phase;
    // RL6 RL8 accumulator, source kept
    // There is no path back to the accumulator and a multiply never raises wr_en,
    // so neither the accumulator nor the source register can change.
    // RL9 no flag write
    assign status_we = 1'b0;

    sequence mul_q4_s;
        s_r.phase == MSX_Q4 && (s_r.kind == MSX_MULLIT || s_r.kind == MSX_MULREG);
    endsequence
    sequence prod_loaded_s;
        ##1 {product_high_byte, product_low_byte} == $past(s_r.product);
    endsequence
    sequence store_q4_s;
        s_r.phase == MSX_Q4 && s_r.kind == MSX_STORE;
    endsequence
    sequence phase_walk_s;
        s_r.phase == MSX_Q2 ##1 s_r.phase == MSX_Q3 ##1 s_r.phase == MSX_Q4
        ##1 s_r.phase == MSX_Q1;
    endsequence

    prod_update_a: assert property (@(posedge clock) disable iff (!rst_n) // RL5
        mul_q4_s |-> prod_loaded_s) else $error("product pair not loaded");
    store_write_a: assert property (@(posedge clock) disable iff (!rst_n) // RL1
        s_r.phase == MSX_Q4 && s_r.kind == MSX_STORE |=> wr_en && wr_data == $past(accum))
        else $error("store did not write accumulator");
    mul_nowrite_a: assert property (@(posedge clock) disable iff (!rst_n) // RL8
        s_r.phase == MSX_Q4 && s_r.kind == MSX_MULREG |=> !wr_en)
        else $error("multiply wrote file register");
    lit_nowrite_a: assert property (@(posedge clock) disable iff (!rst_n) // RL6
        s_r.phase == MSX_Q4 && s_r.kind == MSX_MULLIT |=> !wr_en)
        else $error("literal multiply wrote file");
    no_flags_a: assert property (@(posedge clock) disable iff (!rst_n) // RL9
        !status_we) else $error("status written");
    phase_cycle_a: assert property (@(posedge clock) disable iff (!rst_n) // RL10
        s_r.phase == MSX_Q1 |=> phase_walk_s) else $error("phase order broken");
    mul_value_a: assert property (@(posedge clock) disable iff (!rst_n) // RL4
        s_r.phase == MSX_Q3 && s_r.kind == MSX_MULLIT
        |=> s_r.product == 16'($past(accum)) * 16'($past(s_r.operand)))
        else $error("product wrong");
    bank_addr_a: assert property (@(posedge clock) disable iff (!rst_n) // RL2
        s_r.phase == MSX_Q1 && access_sel
        |=> rd_addr == {$past(bank_select_reg), $past(file_field)})
        else $error("bank select address wrong");
    ilo_addr_a: assert property (@(posedge clock) disable iff (!rst_n) // RL3
        s_r.phase == MSX_Q1 && !access_sel && ext_set_en && file_field <= MSX_ILO_MAX
        |=> rd_addr == {MSX_BANK_ZERO, 8'($past(fsr2_base) + $past(file_field))})
        else $error("indexed address wrong");
    reg_src_a: assert property (@(posedge clock) disable iff (!rst_n) // RL7
        s_r.phase == MSX_Q2 && s_r.kind == MSX_MULREG |=> s_r.operand == $past(rd_data))
        else $error("register operand not taken");

    // The checks below cover the remaining paths: products, operands, addresses, holds between phases and idle cycles.
    reg_value_a: assert property (@(posedge clock) disable iff (!rst_n) // RL7
        s_r.phase == MSX_Q3 && s_r.kind == MSX_MULREG
        |=> s_r.product == 16'($past(accum)) * 16'($past(s_r.operand)))
        else $error("register product wrong");

    lit_operand_a: assert property (@(posedge clock) disable iff (!rst_n) // RL4
        s_r.phase == MSX_Q2 && s_r.kind == MSX_MULLIT |=> s_r.operand == $past(file_field))
        else $error("literal operand not taken");

    access_low_a: assert property (@(posedge clock) disable iff (!rst_n) // RL2
        s_r.phase == MSX_Q1 && !access_sel && !(ext_set_en && file_field <= MSX_ILO_MAX)
        && file_field < MSX_ACCESS_SPLIT |=> rd_addr == {MSX_BANK_ZERO, $past(file_field)})
        else $error("low access bank address wrong");

    access_high_a: assert property (@(posedge clock) disable iff (!rst_n) // RL2
        s_r.phase == MSX_Q1 && !access_sel && file_field >= MSX_ACCESS_SPLIT
        |=> rd_addr == {MSX_ACCESS_HI_BANK, $past(file_field)})
        else $error("high access bank address wrong");

    store_addr_a: assert property (@(posedge clock) disable iff (!rst_n) // RL1
        store_q4_s |=> wr_addr == $past(s_r.addr))
        else $error("store address wrong");

    write_slot_a: assert property (@(posedge clock) disable iff (!rst_n) // RL10
        wr_en |-> s_r.phase == MSX_Q1)
        else $error("write outside its slot");

    prod_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RL5
        s_r.phase != MSX_Q1 |-> $stable({product_high_byte, product_low_byte}))
        else $error("product pair moved mid cycle");

    store_keep_a: assert property (@(posedge clock) disable iff (!rst_n) // RL1
        store_q4_s |=> $stable({product_high_byte, product_low_byte}))
        else $error("store changed product pair");

    none_keep_a: assert property (@(posedge clock) disable iff (!rst_n) // RL10
        s_r.phase == MSX_Q4 && s_r.kind == MSX_NONE
        |=> $stable({product_high_byte, product_low_byte}))
        else $error("unknown opcode changed product pair");

    idle_nowrite_a: assert property (@(posedge clock) disable iff (!rst_n) // RL10
        s_r.phase == MSX_Q4 && s_r.kind == MSX_NONE |=> !wr_en)
        else $error("unknown opcode wrote file");

    kind_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RL10
        s_r.phase != MSX_Q1 |=> $stable(s_r.kind))
        else $error("decoded kind moved mid cycle");

    addr_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RL10
        s_r.phase != MSX_Q1 |=> $stable(rd_addr))
        else $error("read address moved mid cycle");

    wr_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RL1
        s_r.phase != MSX_Q4 |=> $stable({wr_addr, wr_data}))
        else $error("write address or data moved");

    first_phase_a: assert property (@(posedge clock) // RL10
        !rst_n |=> s_r.phase == MSX_Q1 && !wr_en)
        else $error("reset did not return to first phase");
endmodule : msx_exec

//--- test_multiply_and_store_execute.sv
// Self-checking bench for the store and multiply execution unit.
// Assumes msx_exec with a synchronous active-low reset and four clocks per instruction.
module test_multiply_and_store_execute;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [7:0] accum = 8'h00;
    logic [3:0] bank_select_reg = 4'h0;
    logic ext_set_en = 1'b0;
    logic [7:0] fsr2_base = 8'h00;
    logic [7:0] rd_data = 8'h00;
    logic [11:0] rd_addr, wr_addr;
    logic [7:0] wr_data, product_high_byte, product_low_byte;
    logic wr_en, status_we;
    logic [1:0] phase;
    int miscompares = 0;
    int cmp_count = 0;
    int prod = 0;
    int prod_q[$];
    always #12.5 clock = ~clock;
    msx_exec dut (.clock(clock), .rst_n(rst_n), .instr(instr), .accum(accum),
        .bank_select_reg(bank_select_reg), .ext_set_en(ext_set_en), .fsr2_base(fsr2_base),
        .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .product_high_byte(product_high_byte),
        .product_low_byte(product_low_byte), .phase(phase), .status_we(status_we));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_prod(input logic [15:0] got, input int exp);
        chk(got, 16'(exp));
    endtask : chk_prod
    task automatic chk_addr(input logic [11:0] got, input int exp);
        chk(16'(got), 16'(exp));
    endtask : chk_addr
    task automatic chk_data(input logic [7:0] got, input int exp);
        chk(16'(got), 16'(exp));
    endtask : chk_data
    task automatic chk_ctrl(input logic [1:0] got, input int exp);
        chk(16'(got), 16'(exp));
    endtask : chk_ctrl
    task automatic finish_test();
        $display("miscompares %0d comparisons %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    // Kind 3 is an unknown opcode, which must leave the product and file untouched.
    task automatic run(input int kind);
        int f, a, adr, n;
        f = $urandom_range(255);
        a = $urandom_range(1);
        n = 0;
        while (phase !== 2'h0) begin
            n++;
            if (n > 8) begin
                miscompares++;
                finish_test();
            end
            @(negedge clock);
        end
        accum = 8'($urandom);
        bank_select_reg = 4'($urandom);
        ext_set_en = 1'($urandom);
        fsr2_base = 8'($urandom);
        rd_data = 8'($urandom);
        if (a == 1) adr = bank_select_reg * 256 + f;
        else if (ext_set_en && f <= 95) adr = (fsr2_base + f) % 256;
        else adr = (f < 128) ? f : 3840 + f;
        case (kind)
            0: instr = {7'h37, 1'(a), 8'(f)};
            1: instr = {7'h01, 1'(a), 8'(f)};
            2: instr = {8'h0d, 8'(f)};
            default: instr = 16'hffff;
        endcase
        if (kind == 1) prod = accum * rd_data;
        if (kind == 2) prod = accum * f;
        prod_q.push_back(prod);
        repeat (2) @(negedge clock);
        if (kind == 1) chk_addr(rd_addr, adr);
        repeat (2) @(negedge clock);
        chk_prod({product_high_byte, product_low_byte}, prod_q.pop_front());
        chk_ctrl(2'(wr_en), int'(kind == 0));
        if (kind == 0) chk_addr(wr_addr, adr);
        if (kind == 0) chk_data(wr_data, accum);
        chk_ctrl(2'(status_we), 0);
        chk_ctrl(phase, 0);
    endtask : run
    initial begin
        void'($urandom(32'h7d0e));
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        for (int i = 0; i < 200; i++) begin
            run(i % 4);
        end
        finish_test();
    end
endmodule : test_multiply_and_store_execute
